// File: rtl/ssp_pkg.sv
// Notes on behaviour
// RQ1 - Unbuffered slave stays idle while select is high; data may load
// RQ2 - With select low, shifting starts at the first serial clock pulse
// RQ3 - Unbuffered mode sets transfer-done flag after each full byte
// RQ4 - Unbuffered data write during a transfer is dropped; collision flag set
// RQ5 - Select high halts the slave and drops any partial byte
// RQ6 - Buffer-enable bit set to one selects buffered operation
// RQ7 - Buffered, no wait: writes go to buffer; first byte is dummy
// RQ8 - Buffered: pending buffer byte moves to shift register after transfer
// RQ9 - Buffered: write while buffer full is lost, buffer unchanged
// RQ10 - Buffer-empty flag clears on buffer write, sets when buffer copied
// RQ11 - Receive-complete flag sets one cycle after buffer-empty rises
// RQ12 - Transfer-complete sets one cycle later when nothing remains to send
// RQ13 - Wait-for-receive: write with select high loads shift register
// RQ14 - Four phase/polarity modes; shift and sample on opposite edges
// RQ15 - Mode codes: bit1 idle-high clock, bit0 sample on trailing edge
// RQ16 - One combined interrupt fed by select, empty, transfer, receive
// RQ17 - Each source has an enable bit; events set matching flags
// RQ18 - Interrupt asserted while a source is enabled and flagged
// RQ19 - Works in light sleep; deeper sleep aborts any transfer
// RQ20 - Bit-order bit: zero sends MSB first, one sends LSB first
// RQ21 - Serial output driven only while selected and pin set as output
// RQ22 - Master divider field and clock-double bit are held in control
// RQ23 - Master keeps each clock phase longer than two peripheral cycles; there is no master engine, only the control bits are stored
// RQ24 - Serial clock and select are synchronised and edge-detected first
// RQ25 - Port enable at zero keeps shift logic inactive
package ssp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [2:0] IDX_CTRL_P = 3'h0;
  localparam logic [2:0] IDX_CTRL_S = 3'h1;
  localparam logic [2:0] IDX_IRQ_EN = 3'h2;
  localparam logic [2:0] IDX_FLAGS = 3'h3;
  localparam logic [2:0] IDX_DATA = 3'h4;
  // control_primary fields
  localparam int B_ENABLE = 0;
  localparam int B_CLOCK_DOUBLE_BIT = 4;
  localparam int B_MASTER = 5;
  localparam int B_ORDER = 6;
  localparam logic [7:0] CTRL_P_MASK = 8'h7_7;
  localparam logic [7:0] CTRL_P_RST = 8'h0_0;
  // control_secondary fields
  localparam int B_BUFFER_ENABLE_BIT = 7;
  localparam int B_WAITRX = 6;
  localparam int B_CPOL = 1;
  localparam int B_CPHA = 0;
  localparam logic [7:0] CTRL_S_MASK = 8'hC_7;
  localparam logic [7:0] CTRL_S_RST = 8'h0_0;
  // Interrupt enable and flag fields
  localparam int B_RXC = 7;
  localparam int B_TXC = 6;
  localparam int B_DRE = 5;
  localparam int B_SSI = 4;
  localparam int B_UNBUF = 0;
  localparam logic [7:0] IRQ_EN_MASK = 8'hF_1;
  localparam logic [7:0] IRQ_EN_RST = 8'h0_0;
  localparam logic [7:0] DATA_RST = 8'h0_0;
  localparam int BITS = 8;
  localparam int RX_DEPTH = 2;
endpackage : ssp_pkg

// File: rtl/ssp_sync.sv
`timescale 1ns/1ns
`default_nettype none
module ssp_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ssp_sync_t;

  ssp_sync_t s_r;
  ssp_sync_t s_nxt;

  // First stage feeds only the second stage
  always_comb
  begin
    s_nxt.s1 = i_d;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      s_r <= {RST_VAL, RST_VAL};
    else
      s_r <= s_nxt;
  end

  assign o_q = s_r.s2;
endmodule : ssp_sync
`default_nettype wire

// File: rtl/ssp_rx_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module ssp_rx_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_flush,
  input wire logic i_push,
  input wire logic [W-1:0] i_data,
  input wire logic i_pop,
  output logic [W-1:0] o_head,
  output logic o_empty,
  output logic o_full
);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [CW-1:0] cnt;
  } ssp_fifo_t;

  ssp_fifo_t s_r;
  ssp_fifo_t s_nxt;

  // Head always sits in entry zero so the read port is a register
  always_comb
  begin
    s_nxt = s_r;
    if (i_flush)
      s_nxt.cnt = '0;
    else if (i_pop && s_r.cnt != '0)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
        s_nxt.mem[i] = s_r.mem[i+1];
      s_nxt.cnt = s_r.cnt - CW'(1);
    end
    // A push into a full queue is dropped; caller flags overflow
    if (i_push && s_nxt.cnt < CW'(DEPTH))
    begin
      s_nxt.mem[s_nxt.cnt] = i_data;
      s_nxt.cnt = s_nxt.cnt + CW'(1);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign o_head = s_r.mem[0];
  assign o_empty = (s_r.cnt == '0);
  assign o_full = (s_r.cnt == CW'(DEPTH));
endmodule : ssp_rx_fifo
`default_nettype wire

// File: rtl/ssp_spi_slave.sv
`timescale 1ns/1ns
`default_nettype none
module ssp_spi_slave #(
  parameter int ADR_W = 5
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [ADR_W-1:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_sel,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_sck,
  input wire logic i_ss_n,
  input wire logic i_mosi,
  input wire logic i_miso_dir,
  input wire logic i_deep_sleep,
  output logic o_miso,
  output logic o_miso_oe,
  output logic o_irq
);
  import ssp_pkg::*;

  // Byte engine: idle until the first sample edge of a byte
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } ssp_state_t;

  // All state of the block except the synchroniser and receive queue in one record
  typedef struct packed {
    ssp_state_t st;
    logic [7:0] ctl_p;
    logic [7:0] ctl_s;
    logic [7:0] ien;
    logic f7;
    logic f6;
    logic select_trigger_flag;
    logic ovf;
    logic armed;
    logic [BITS-1:0] sh;
    logic [BITS-1:0] txb;
    logic txfull;
    logic sh_loaded;
    logic [2:0] cnt;
    logic pend;
    logic rbit;
    logic sck_q;
    logic ss_q;
    logic done_d1;
    logic done_d2;
    logic was_empty;
    logic ack;
    logic [7:0] rdat;
    logic miso;
    logic oe;
    logic irq;
  } ssp_regs_t;

  ssp_regs_t s_r;
  ssp_regs_t s_nxt;

  // Synchronised pins and receive queue handshake
  logic [2:0] sync_q;
  logic sck_s;
  logic ss_n_s;
  logic mosi_s;
  logic fifo_push;
  logic fifo_pop;
  logic fifo_flush;
  logic [BITS-1:0] fifo_head;
  logic fifo_empty;
  logic fifo_full;
  logic [BITS-1:0] fifo_din;

  // One bit enters the shift register, the other end leaves
  function automatic logic [BITS-1:0] shift_in(
    input logic [BITS-1:0] v,
    input logic b,
    input logic lsb_first
  );
    if (lsb_first)
      shift_in = {b, v[BITS-1:1]};
    else
      shift_in = {v[BITS-2:0], b};
  endfunction : shift_in

  // Mode codes 1 and 2 sample on the falling serial clock edge
  function automatic logic sample_on_fall(
    input logic [7:0] ctl
  );
    sample_on_fall = ctl[B_CPOL] ^ ctl[B_CPHA];
  endfunction : sample_on_fall

  // Pins are brought into the peripheral clock before any use
  ssp_sync #(
    .W(3),
    .RST_VAL(3'h2)
  ) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_d({i_sck, i_ss_n, i_mosi}),
    .o_q(sync_q)
  ); // RQ24
  assign sck_s = sync_q[2];
  assign ss_n_s = sync_q[1];
  assign mosi_s = sync_q[0];

  ssp_rx_fifo #(
    .W(BITS),
    .DEPTH(RX_DEPTH)
  ) u_rx (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_flush(fifo_flush),
    .i_push(fifo_push),
    .i_data(fifo_din),
    .i_pop(fifo_pop),
    .o_head(fifo_head),
    .o_empty(fifo_empty),
    .o_full(fifo_full)
  );

  // Whole block: bus slave, shifter and flag logic in one pass
  always_comb
  begin
    logic req;
    logic wr;
    logic rd;
    logic hit;
    logic [2:0] idx;
    logic [7:0] wd;
    logic bufm;
    logic lsb;
    logic act;
    logic rise;
    logic fall;
    logic samp;
    logic setp;
    logic done;
    logic ss_fall;
    logic [7:0] flags;
    req = i_wb_cyc && i_wb_stb && !s_r.ack;
    idx = i_wb_adr[4:2];
    hit = (i_wb_adr[1:0] == 2'h0) && (idx <= IDX_DATA);
    wr = req && hit && i_wb_we && i_wb_sel[0];
    rd = req && hit && !i_wb_we;
    wd = i_wb_dat[7:0];
    bufm = s_r.ctl_s[B_BUFFER_ENABLE_BIT]; // RQ6
    lsb = s_r.ctl_p[B_ORDER];
    // Queue takes the finished byte, not a refill from the buffer
    fifo_din = shift_in(s_r.sh, mosi_s, lsb);
    // Deeper sleep and disable look like a deselect
    act = s_r.ctl_p[B_ENABLE] && !ss_n_s && !i_deep_sleep; // RQ25 RQ19
    rise = sck_s && !s_r.sck_q;
    fall = !sck_s && s_r.sck_q;
    // Leading edge rises when idle low; cpha moves sampling to trailing
    samp = sample_on_fall(s_r.ctl_s) ? fall : rise; // RQ15
    setp = sample_on_fall(s_r.ctl_s) ? rise : fall; // RQ14
    ss_fall = !ss_n_s && s_r.ss_q;
    done = 1'b0;
    flags = 8'h0_0;
    fifo_push = 1'b0;
    fifo_pop = 1'b0;
    fifo_flush = 1'b0;
    // Defaults: hold state, follow the pins, age the flag delay line
    s_nxt = s_r;
    s_nxt.ack = req;
    s_nxt.sck_q = sck_s;
    s_nxt.ss_q = ss_n_s;
    s_nxt.done_d1 = 1'b0;
    s_nxt.done_d2 = s_r.done_d1;

    // Data access completes the read-flags-then-data clear sequence
    if (!bufm && (wr || rd) && idx == IDX_DATA && s_r.armed)
    begin
      s_nxt.f7 = 1'b0;
      s_nxt.f6 = 1'b0;
      s_nxt.armed = 1'b0;
    end

    // Register writes; flag clears go first so hardware sets win
    if (wr)
    begin
      case (idx)
        // Divider and clock-double are stored only; no master engine here
        IDX_CTRL_P: s_nxt.ctl_p = wd & CTRL_P_MASK; // RQ22
        IDX_CTRL_S: s_nxt.ctl_s = wd & CTRL_S_MASK;
        IDX_IRQ_EN: s_nxt.ien = wd & IRQ_EN_MASK;
        IDX_FLAGS:
        begin
          s_nxt.f7 = s_r.f7 && !wd[B_RXC];
          s_nxt.f6 = s_r.f6 && !wd[B_TXC];
          s_nxt.select_trigger_flag = s_r.select_trigger_flag && !wd[B_SSI];
          s_nxt.ovf = s_r.ovf && !wd[B_UNBUF];
        end
        IDX_DATA:
        begin
          if (!bufm)
          begin
            if (s_r.st == ST_BUSY)
              s_nxt.f6 = 1'b1; // RQ4
            else
              s_nxt.sh = wd; // RQ1
          end
          else if (s_r.ctl_s[B_WAITRX] && ss_n_s && !s_r.sh_loaded
                   && !s_r.txfull)
          begin
            s_nxt.sh = wd; // RQ13
            s_nxt.sh_loaded = 1'b1;
          end
          else if (!s_r.txfull) // RQ9
          begin
            s_nxt.txb = wd; // RQ7
            s_nxt.txfull = 1'b1; // RQ10
          end
        end
        default: s_nxt.ctl_p = s_r.ctl_p;
      endcase
    end

    if (rd && idx == IDX_FLAGS && !bufm && s_r.f7)
      s_nxt.armed = 1'b1;
    if (rd && idx == IDX_DATA && bufm)
      fifo_pop = 1'b1;

    // Serial engine; outside selection the count restarts
    if (!act)
    begin
      s_nxt.cnt = 3'h0; // RQ5
      s_nxt.pend = 1'b0;
      s_nxt.st = ST_IDLE;
    end
    else if (samp)
    begin
      s_nxt.st = ST_BUSY; // RQ2
      if (s_r.cnt == 3'h7)
      begin
        s_nxt.sh = shift_in(s_r.sh, mosi_s, lsb);
        s_nxt.cnt = 3'h0;
        s_nxt.pend = 1'b0;
        s_nxt.st = ST_IDLE;
        done = 1'b1;
      end
      else
      begin
        s_nxt.rbit = mosi_s;
        s_nxt.pend = 1'b1;
        s_nxt.cnt = s_r.cnt + 3'h1;
      end
    end
    else if (setp && s_r.pend)
    begin
      // Held bit enters only on the setup edge so the output stays put
      s_nxt.sh = shift_in(s_r.sh, s_r.rbit, lsb); // RQ14
      s_nxt.pend = 1'b0;
    end

    // End of byte: store receive data, refill from the buffer
    if (done)
    begin
      fifo_push = 1'b1;
      fifo_flush = !bufm;
      s_nxt.sh_loaded = 1'b0;
      if (!bufm)
        s_nxt.f7 = 1'b1; // RQ3
      else
      begin
        if (fifo_full && !fifo_pop)
          s_nxt.ovf = 1'b1;
        s_nxt.done_d1 = 1'b1;
        s_nxt.was_empty = !s_r.txfull;
        if (s_r.txfull)
        begin
          s_nxt.sh = s_r.txb; // RQ8
          s_nxt.txfull = 1'b0; // RQ10
        end
      end
    end
    // Buffered chain: receive one cycle after refill, then transfer
    if (bufm && s_r.done_d1)
      s_nxt.f7 = 1'b1; // RQ11
    else if (bufm && fifo_empty && !fifo_push)
      s_nxt.f7 = 1'b0;
    if (bufm && s_r.done_d2 && s_r.was_empty && !s_r.txfull)
      s_nxt.f6 = 1'b1; // RQ12
    // Select trigger flag on each falling select in buffered mode while the port is enabled
    if (bufm && ss_fall && s_r.ctl_p[B_ENABLE])
      s_nxt.select_trigger_flag = 1'b1; // RQ17

    // Status view and read data
    flags = {s_r.f7, s_r.f6, bufm && !s_r.txfull, s_r.select_trigger_flag, 3'h0, s_r.ovf};
    s_nxt.rdat = 8'h0_0;
    if (rd)
    begin
      case (idx)
        IDX_CTRL_P: s_nxt.rdat = s_r.ctl_p;
        IDX_CTRL_S: s_nxt.rdat = s_r.ctl_s;
        IDX_IRQ_EN: s_nxt.rdat = s_r.ien;
        IDX_FLAGS: s_nxt.rdat = flags;
        IDX_DATA: s_nxt.rdat = fifo_head;
        default: s_nxt.rdat = 8'h0_0;
      endcase
    end

    // One combined request from the enabled sources
    if (bufm)
      s_nxt.irq = |(flags[7:4] & s_r.ien[7:4]); // RQ16 RQ18
    else
      s_nxt.irq = s_r.ien[B_UNBUF] && s_r.f7; // RQ18

    // Output pin only driven while selected and set as output
    s_nxt.miso = lsb ? s_r.sh[0] : s_r.sh[BITS-1]; // RQ20
    s_nxt.oe = i_miso_dir && act; // RQ21
  end

  // Reset idle levels of the edge detectors match the idle pins
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      s_r <= '0;
      s_r.ctl_p <= CTRL_P_RST;
      s_r.ctl_s <= CTRL_S_RST;
      s_r.ien <= IRQ_EN_RST;
      s_r.sh <= DATA_RST;
      s_r.sck_q <= 1'b0;
      s_r.ss_q <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // Ports come straight from the state record
  assign o_wb_dat = {24'h00_0000, s_r.rdat};
  assign o_wb_ack = s_r.ack;
  assign o_miso = s_r.miso;
  assign o_miso_oe = s_r.oe;
  assign o_irq = s_r.irq;
endmodule : ssp_spi_slave
`default_nettype wire

// File: testbench/ssp_spi_slave_props.sv
`timescale 1ns/1ns
`default_nettype none
module ssp_spi_slave_props
  import ssp_pkg::*;
#(
  parameter int ADR_W = 5
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [ADR_W-1:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_sel,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_sck,
  input wire logic i_ss_n,
  input wire logic i_mosi,
  input wire logic i_miso_dir,
  input wire logic i_deep_sleep,
  input wire logic o_miso,
  input wire logic o_miso_oe,
  input wire logic o_irq
);
  logic [7:0] en_r;
  logic on_r;
  logic take;
  // Shadows of enables; assertions allow slack for the write latency
  assign take = i_wb_cyc && i_wb_stb && i_wb_we && i_wb_sel[0] && !o_wb_ack;
  always_ff @(posedge i_clk)
  begin
    en_r <= i_reset ? 8'h00
      : (take && i_wb_adr == 5'h08) ? i_wb_dat[7:0] : en_r;
    on_r <= i_reset ? 1'b0
      : (take && i_wb_adr == 5'h00) ? i_wb_dat[0] : on_r;
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  // Quiet outputs in reset, bus handshake and idle read data
  property p_quiet;
    disable iff (1'b0) i_reset |=> !o_wb_ack && !o_irq && !o_miso_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("active in reset");
  property p_ack; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_pulse; o_wb_ack |=> !o_wb_ack; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_dat; !o_wb_ack |-> o_wb_dat == 32'h0000_0000; endproperty
  a_dat: assert property (p_dat) else $error("data without ack");
  // Output enable follows direction, select, sleep and port enable; irq stays low while all enables are clear
  property p_dir; !i_miso_dir [*3] |-> !o_miso_oe; endproperty
  a_dir: assert property (p_dir) else $error("driven as input");
  property p_sel; i_ss_n [*6] |-> !o_miso_oe; endproperty
  a_sel: assert property (p_sel) else $error("driven unselected");
  property p_slp; i_deep_sleep [*4] |-> !o_miso_oe; endproperty
  a_slp: assert property (p_slp) else $error("driven in sleep");
  property p_off; !on_r [*4] |-> !o_miso_oe; endproperty
  a_off: assert property (p_off) else $error("driven when off");
  property p_irq; (en_r == 8'h00) [*4] |-> !o_irq; endproperty
  a_irq: assert property (p_irq) else $error("irq masked");
endmodule : ssp_spi_slave_props
bind ssp_spi_slave ssp_spi_slave_props #(.ADR_W(ADR_W)) i_props (
  .i_clk(i_clk), .i_reset(i_reset), .i_wb_adr(i_wb_adr),
  .i_wb_dat(i_wb_dat), .i_wb_we(i_wb_we), .i_wb_sel(i_wb_sel),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack), .i_sck(i_sck), .i_ss_n(i_ss_n), .i_mosi(i_mosi),
  .i_miso_dir(i_miso_dir), .i_deep_sleep(i_deep_sleep),
  .o_miso(o_miso), .o_miso_oe(o_miso_oe), .o_irq(o_irq));
`default_nettype wire

// File: testbench/ssp_spi_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module ssp_spi_master_model (
  input wire logic i_clk,
  input wire logic i_miso,
  output logic o_sck,
  output logic o_ss_n,
  output logic o_mosi
);
  // Idle: deselected, clock still
  initial
  begin
    o_sck = 1'b0;
    o_ss_n = 1'b1;
    o_mosi = 1'b0;
  end
  // Phases of 8 cycles also cover the slave's 4-5 cycle output delay
  task automatic xfer(input logic [1:0] mode, input logic lsb,
    input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    int k;
    rx = 8'h00;
    @(posedge i_clk);
    o_sck <= mode[1];
    repeat (8) @(posedge i_clk);
    o_ss_n <= 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      k = lsb ? i : 7 - i;
      o_mosi <= mode[0] ? o_mosi : tx[k];
      repeat (8) @(posedge i_clk);
      rx[k] = mode[0] ? rx[k] : i_miso;
      o_sck <= ~mode[1];
      o_mosi <= tx[k];
      repeat (8) @(posedge i_clk);
      rx[k] = mode[0] ? i_miso : rx[k];
      o_sck <= mode[1];
    end
    repeat (8) @(posedge i_clk);
    // Released line shows the inverse of its last bit
    o_ss_n <= 1'b1;
    o_mosi <= ~o_mosi;
    repeat (8) @(posedge i_clk);
  endtask : xfer
endmodule : ssp_spi_master_model
`default_nettype wire

// File: testbench/ssp_spi_slave_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module ssp_spi_slave_tb_top;
  import ssp_pkg::*;
  localparam logic [4:0] A_CP = {IDX_CTRL_P, 2'b00};
  localparam logic [4:0] A_CS = {IDX_CTRL_S, 2'b00};
  localparam logic [4:0] A_IE = {IDX_IRQ_EN, 2'b00};
  localparam logic [4:0] A_FL = {IDX_FLAGS, 2'b00};
  localparam logic [4:0] A_DT = {IDX_DATA, 2'b00};
  logic clk, rst = 1'b1, wb_we = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0;
  logic dir = 1'b0, slp = 1'b1, ack, miso, oe, irq, sck, ss_n, mosi;
  logic [4:0] wb_adr = 5'h00;
  logic [3:0] wb_sel = 4'hF;
  logic [31:0] wb_dat = 32'h0000_0000, rdat;
  logic [7:0] q, rx;
  int miscompares = 0, comparisons = 0;
  // Undriven pin shows the inverse of the last bit
  wire logic miso_w = oe ? miso : ~miso;
  ssp_spi_slave #(.ADR_W(5)) i_dut (.i_clk(clk), .i_reset(rst),
    .i_wb_adr(wb_adr), .i_wb_dat(wb_dat), .i_wb_we(wb_we),
    .i_wb_sel(wb_sel), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_sck(sck), .i_ss_n(ss_n),
    .i_mosi(mosi), .i_miso_dir(dir), .i_deep_sleep(slp), .o_miso(miso),
    .o_miso_oe(oe), .o_irq(irq));
  ssp_spi_master_model i_master (.i_clk(clk), .i_miso(miso_w),
    .o_sck(sck), .o_ss_n(ss_n), .o_mosi(mosi));
  // 100 ns clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // One classic cycle; a missing ack counts as a mismatch
  task automatic wb(input logic we, input logic [4:0] a, input logic [7:0] d,
    output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk);
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= {24'h00_0000, d};
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    do
      @(posedge clk);
    while (ack !== 1'b1 && ++n < 9);
    if (n >= 9)
      miscompares++;
    r = rdat[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, a, d, r);
  endtask : wr
  task automatic t_regs();
    wb(1'b0, A_CP, 8'h00, q);
    chk(q, CTRL_P_RST);
    wr(A_CP, 8'hFF);
    wb(1'b0, A_CP, 8'h00, q);
    chk(q, 8'h77);
    wr(A_IE, 8'hFF);
    wb(1'b0, A_IE, 8'h00, q);
    chk(q, 8'hF1);
    wr(A_IE, 8'h00);
    wb(1'b0, 5'h14, 8'h00, q);
    chk(q, 8'h00);
  endtask : t_regs
  task automatic t_modes();
    for (int i = 0; i < 8; i++)
    begin
      wr(A_CP, {1'b0, i[2], 6'h01});
      wr(A_CS, {6'h00, i[1:0]});
      wr(A_DT, 8'h1E + 8'(i));
      i_master.xfer(i[1:0], i[2], 8'hB4 ^ 8'(i), 8, rx);
      chk(rx, 8'h1E + 8'(i));
      wb(1'b0, A_DT, 8'h00, q);
      chk(q, 8'hB4 ^ 8'(i));
    end
    wr(A_IE, 8'h01);
    repeat (4) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    wb(1'b0, A_FL, 8'h00, q);
    chk(q & 8'h80, 8'h80);
    wb(1'b0, A_DT, 8'h00, q);
    repeat (4) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    wr(A_IE, 8'h00);
  endtask : t_modes
  task automatic t_write_collision_flag();
    wr(A_CP, 8'h01);
    wr(A_CS, 8'h00);
    wr(A_DT, 8'h5A);
    fork
      i_master.xfer(2'b00, 1'b0, 8'h00, 8, rx);
      begin
        repeat (40) @(posedge clk);
        wr(A_DT, 8'hFF);
      end
    join
    chk(rx, 8'h5A);
    wb(1'b0, A_FL, 8'h00, q);
    chk(q & 8'h40, 8'h40);
  endtask : t_write_collision_flag
  task automatic t_abort();
    i_master.xfer(2'b00, 1'b0, 8'hF0, 4, rx);
    i_master.xfer(2'b00, 1'b0, 8'h69, 8, rx);
    wb(1'b0, A_DT, 8'h00, q);
    chk(q, 8'h69);
  endtask : t_abort
  task automatic t_buf();
    wr(A_CS, 8'h80);
    // Drain the byte left over from unbuffered operation
    wb(1'b0, A_DT, 8'h00, q);
    chk(q, 8'h69);
    wr(A_DT, 8'h43);
    wb(1'b0, A_FL, 8'h00, q);
    chk(q & 8'h20, 8'h00);
    i_master.xfer(2'b00, 1'b0, 8'h01, 8, rx);
    chk(rx, 8'h69);
    wb(1'b0, A_FL, 8'h00, q);
    chk(q & 8'hF0, 8'hB0);
    wr(A_IE, 8'h80);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    wr(A_IE, 8'h00);
    wr(A_DT, 8'h44);
    wr(A_DT, 8'h45);
    i_master.xfer(2'b00, 1'b0, 8'h02, 8, rx);
    chk(rx, 8'h43);
    i_master.xfer(2'b00, 1'b0, 8'h03, 8, rx);
    chk(rx, 8'h44);
    wb(1'b0, A_FL, 8'h00, q);
    chk(q & 8'hC1, 8'hC1);
    wb(1'b0, A_DT, 8'h00, q);
    chk(q, 8'h01);
    wr(A_CS, 8'hC0);
    wr(A_DT, 8'h77);
    i_master.xfer(2'b00, 1'b0, 8'h04, 8, rx);
    chk(rx, 8'h77);
  endtask : t_buf
  task automatic results();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    dir <= 1'b1;
    slp <= 1'b0;
    t_modes();
    t_write_collision_flag();
    t_abort();
    t_buf();
    results();
  end
  // Watchdog, far beyond the expected run
  initial
  begin
    #2000000;
    miscompares++;
    results();
  end
endmodule : ssp_spi_slave_tb_top
`default_nettype wire
